// File: src/rstc_pkg.sv
// Constants for the receive section termination configuration block.
// Assumes an APB master and a frame tick on the block's own clock.
package rstc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TRACE_CTRL = 8'h0E;
  localparam logic [7:0] IDX_TRACE_DATA = 8'h0F;
  localparam logic [7:0] IDX_CLR_SIZE_LO = 8'h15;
  localparam logic [7:0] IDX_CLR_SIZE_HI = 8'h16;
  localparam logic [7:0] IDX_CLR_COUNT = 8'h17;
  localparam logic [7:0] IDX_CEILING = 8'h18;
  localparam logic [7:0] IDX_SET_SIZE_LO = 8'h1B;
  localparam logic [7:0] IDX_SET_SIZE_HI = 8'h1C;
  localparam logic [7:0] IDX_SET_COUNT = 8'h1D;
  localparam logic [7:0] IDX_THRESHOLD = 8'h1E;
  localparam logic [7:0] IDX_STATUS = 8'h30;
  localparam logic [7:0] IDX_INT_STATUS = 8'h31;
  localparam logic [7:0] IDX_INT_MASK = 8'h32;

  // Field positions
  localparam int CTRL_PTR_RESET_BIT = 0;
  localparam int CTRL_ACCESS_BIT = 1;
  localparam int STATUS_FLAG_BIT = 0;
  localparam int INT_SET_BIT = 0;
  localparam int INT_CLR_BIT = 1;
  localparam int INT_W = 2;

  // Widths and depths
  localparam int STR_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int WIN_SIZE_W = 11;
  localparam int WIN_CNT_W = 7;
  localparam int FRAME_CNT_W = 14;
  localparam int ERR_CNT_W = 16;

  // Reset values
  localparam logic [WIN_SIZE_W-1:0] RST_WIN_SIZE = 11'h000;
  localparam logic [WIN_CNT_W-1:0] RST_SET_COUNT = 7'h03;
  localparam logic [WIN_CNT_W-1:0] RST_CLR_COUNT = 7'h07;
  localparam logic [7:0] RST_THRESHOLD = 8'h2B;
  localparam logic [7:0] RST_CEILING = 8'h08;

  typedef enum logic {RSTC_SET_MODE, RSTC_CLR_MODE} rstc_mode_type;

endpackage

// File: src/rstc_window.sv
// One window evaluator: counts B2 errors over back-to-back windows.
// Assumes frame_tick and err_pulse are one-cycle pulses on clk.
`timescale 1ns/10ps
module rstc_window #(
  parameter rstc_pkg::rstc_mode_type MODE = rstc_pkg::RSTC_SET_MODE
) (
  input logic clk,
  input logic reset,
  input logic frame_tick,
  input logic err_pulse,
  input logic [rstc_pkg::WIN_SIZE_W-1:0] win_size,
  input logic [7:0] threshold,
  output logic done_r,
  output logic qual_r,
  output logic [rstc_pkg::WIN_CNT_W-1:0] run_r
);

  logic [rstc_pkg::FRAME_CNT_W-1:0] frame_cnt_r;
  logic [rstc_pkg::ERR_CNT_W-1:0] err_cnt_r;
  logic [rstc_pkg::ERR_CNT_W-1:0] err_total;
  logic [rstc_pkg::FRAME_CNT_W-1:0] last_frame;
  logic window_end;
  logic qual_now;

  ////////////////////////////////////////////////////////////////////////
  // Window length is 8*(v+1) frames; last index is {v,3'b111}
  assign last_frame = {win_size, 3'h7};
  // Compare with >= so a size shrunk mid-window ends at the next frame tick
  assign window_end = frame_tick && (frame_cnt_r >= last_frame);
  // Saturate rather than wrap on long windows
  assign err_total = (err_cnt_r == 16'hFFFF) ? err_cnt_r :
    err_cnt_r + {15'h0000, err_pulse};

  always_comb
  begin
    if (MODE == rstc_pkg::RSTC_SET_MODE)
    begin
      qual_now = (threshold == 8'h00) ||
        (err_total >= {8'h00, threshold});
    end
    else
    begin
      qual_now = (threshold == 8'h00) ||
        (err_total <= {8'h00, threshold});
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      frame_cnt_r <= 14'h0000;
    else if (window_end)
      frame_cnt_r <= 14'h0000;
    else if (frame_tick)
      frame_cnt_r <= frame_cnt_r + 14'h0001;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      err_cnt_r <= 16'h0000;
    else if (window_end)
      err_cnt_r <= 16'h0000;
    else
      err_cnt_r <= err_total;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      done_r <= 1'b0;
      qual_r <= 1'b0;
      run_r <= 7'h00;
    end
    else
    begin
      done_r <= window_end;
      if (window_end)
      begin
        qual_r <= qual_now;
        if (!qual_now)
          run_r <= 7'h00;
        else if (run_r != 7'h7F)
          run_r <= run_r + 7'h01;
      end
    end
  end

  a_window_restart: assert property (@(posedge clk) disable iff (reset)
    window_end |=> (frame_cnt_r == 14'h0000) && (err_cnt_r == 16'h0000))
    else $error("window did not restart");

  a_run_broken: assert property (@(posedge clk) disable iff (reset)
    (done_r && !qual_r) |-> (run_r == 7'h00))
    else $error("run not restarted after failing window");

  a_zero_thr_qual: assert property (@(posedge clk) disable iff (reset)
    (window_end && threshold == 8'h00) |=> (done_r && qual_r))
    else $error("zero threshold window not qualified");

endmodule

// File: src/rstc_top.sv
// Receive section termination configuration: trace string port and
// excessive B2 set/clear window logic behind an APB slave.
// Assumes APB, frame tick, B2 error pulses and pointer advance on CLK.
//
// Operation
// - Access bit one: each software data read or write advances pointer.
// - Access bit zero: the trace comparison hardware advances the pointer.
// - Rising edge written to pointer-reset bit returns pointer to byte zero.
// - Software mode: data access uses pointed byte, then pointer increments.
// - Set and clear windows last eight times field plus one frames.
// - Window is excessive when errors reach the threshold, reset 2B.
// - Zero threshold makes every set window excessive.
// - Flag sets when consecutive excessive windows reach set count, reset 3.
// - With flag clear and set count zero, flag never sets.
// - Flag clears when consecutive good windows reach clear count, reset 7.
// - With flag set and clear count zero, flag never clears.
// - Window sizes are two byte registers, high byte at higher index.
// - Clear window is good when errors do not exceed ceiling or ceiling is zero, reset 08.
`timescale 1ns/10ps
module rstc_top (
  input logic CLK,
  input logic RESET,
  input logic PSEL,
  input logic PENABLE,
  input logic PWRITE,
  input logic [9:0] PADDR,
  input logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input logic FRAME_TICK,
  input logic B2_ERROR,
  input logic HW_PTR_ADVANCE,
  output logic [7:0] EXPECTED_BYTE,
  output logic [rstc_pkg::PTR_W-1:0] EXPECTED_POINTER,
  output logic EXCESSIVE_PARITY_ERROR_FLAG,
  output logic IRQ
);

  logic [7:0] mem_r [rstc_pkg::STR_DEPTH];
  logic [rstc_pkg::PTR_W-1:0] ptr_r;
  logic software_string_access_r;
  logic expected_string_pointer_reset_r;
  logic [rstc_pkg::WIN_SIZE_W-1:0] set_window_size_field_r;
  logic [rstc_pkg::WIN_SIZE_W-1:0] clear_window_size_field_r;
  logic [rstc_pkg::WIN_CNT_W-1:0] set_window_count_field_r;
  logic [rstc_pkg::WIN_CNT_W-1:0] clear_window_count_field_r;
  logic [7:0] excessive_error_threshold_r;
  logic [7:0] nonexcessive_error_ceiling_r;
  logic flag_r;
  logic [rstc_pkg::INT_W-1:0] int_status_r;
  logic [rstc_pkg::INT_W-1:0] int_status_nxt;
  logic [rstc_pkg::INT_W-1:0] int_mask_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [7:0] exp_byte_r;
  logic irq_r;

  logic [7:0] idx;
  logic mapped;
  logic start;
  logic done;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_mux;
  logic data_access;
  logic ptr_reset_edge;
  logic sw_advance;
  logic hw_advance;
  logic set_done;
  logic set_qual;
  logic [rstc_pkg::WIN_CNT_W-1:0] set_run;
  logic clr_done;
  logic clr_qual;
  logic [rstc_pkg::WIN_CNT_W-1:0] clr_run;
  logic flag_set;
  logic flag_clr;

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state on every transfer, so read data is
  // captured from a registered mux instead of a long combinational path
  assign idx = PADDR[9:2];
  assign start = PSEL && PENABLE && !pready_r;
  assign done = PSEL && PENABLE && pready_r;
  assign wr_en = done && PWRITE && mapped;
  assign rd_en = done && !PWRITE && mapped;

  always_comb
  begin
    mapped = (PADDR[1:0] == 2'h0);
    rd_mux = 32'h00000000;
    case (idx)
      // Control bits are write-only and read as zero
      rstc_pkg::IDX_TRACE_CTRL: rd_mux = 32'h00000000;
      rstc_pkg::IDX_TRACE_DATA: rd_mux[7:0] = mem_r[ptr_r];
      rstc_pkg::IDX_CLR_SIZE_LO: rd_mux[7:0] = clear_window_size_field_r[7:0];
      rstc_pkg::IDX_CLR_SIZE_HI:
        rd_mux[2:0] = clear_window_size_field_r[10:8];
      rstc_pkg::IDX_CLR_COUNT: rd_mux[6:0] = clear_window_count_field_r;
      rstc_pkg::IDX_CEILING: rd_mux[7:0] = nonexcessive_error_ceiling_r;
      rstc_pkg::IDX_SET_SIZE_LO: rd_mux[7:0] = set_window_size_field_r[7:0];
      rstc_pkg::IDX_SET_SIZE_HI:
        rd_mux[2:0] = set_window_size_field_r[10:8];
      rstc_pkg::IDX_SET_COUNT: rd_mux[6:0] = set_window_count_field_r;
      rstc_pkg::IDX_THRESHOLD: rd_mux[7:0] = excessive_error_threshold_r;
      rstc_pkg::IDX_STATUS: rd_mux[rstc_pkg::STATUS_FLAG_BIT] = flag_r;
      rstc_pkg::IDX_INT_STATUS: rd_mux[1:0] = int_status_r;
      rstc_pkg::IDX_INT_MASK: rd_mux[1:0] = int_mask_r;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= start;
      pslverr_r <= start && !mapped;
      if (start && !PWRITE && mapped)
        prdata_r <= rd_mux;
      else if (done)
        prdata_r <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      software_string_access_r <= 1'b0;
      expected_string_pointer_reset_r <= 1'b0;
      set_window_size_field_r <= rstc_pkg::RST_WIN_SIZE;
      clear_window_size_field_r <= rstc_pkg::RST_WIN_SIZE;
      set_window_count_field_r <= rstc_pkg::RST_SET_COUNT;
      clear_window_count_field_r <= rstc_pkg::RST_CLR_COUNT;
      excessive_error_threshold_r <= rstc_pkg::RST_THRESHOLD;
      nonexcessive_error_ceiling_r <= rstc_pkg::RST_CEILING;
      int_mask_r <= 2'h0;
    end
    else if (wr_en)
    begin
      case (idx)
        rstc_pkg::IDX_TRACE_CTRL:
        begin
          software_string_access_r <= PWDATA[rstc_pkg::CTRL_ACCESS_BIT];
          expected_string_pointer_reset_r <=
            PWDATA[rstc_pkg::CTRL_PTR_RESET_BIT];
        end
        rstc_pkg::IDX_CLR_SIZE_LO:
          clear_window_size_field_r[7:0] <= PWDATA[7:0];
        rstc_pkg::IDX_CLR_SIZE_HI:
          clear_window_size_field_r[10:8] <= PWDATA[2:0];
        rstc_pkg::IDX_CLR_COUNT: clear_window_count_field_r <= PWDATA[6:0];
        rstc_pkg::IDX_CEILING: nonexcessive_error_ceiling_r <= PWDATA[7:0];
        rstc_pkg::IDX_SET_SIZE_LO:
          set_window_size_field_r[7:0] <= PWDATA[7:0];
        rstc_pkg::IDX_SET_SIZE_HI:
          set_window_size_field_r[10:8] <= PWDATA[2:0];
        rstc_pkg::IDX_SET_COUNT: set_window_count_field_r <= PWDATA[6:0];
        rstc_pkg::IDX_THRESHOLD: excessive_error_threshold_r <= PWDATA[7:0];
        rstc_pkg::IDX_INT_MASK: int_mask_r <= PWDATA[1:0];
        default: int_mask_r <= int_mask_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Expected string pointer; reset beats any advance in the same cycle
  assign data_access = done && mapped && (idx == rstc_pkg::IDX_TRACE_DATA);
  assign ptr_reset_edge = wr_en && (idx == rstc_pkg::IDX_TRACE_CTRL) &&
    PWDATA[rstc_pkg::CTRL_PTR_RESET_BIT] &&
    !expected_string_pointer_reset_r;
  assign sw_advance = software_string_access_r && data_access;
  assign hw_advance = !software_string_access_r && HW_PTR_ADVANCE;

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      ptr_r <= 4'h0;
    else if (ptr_reset_edge)
      ptr_r <= 4'h0;
    else if (sw_advance || hw_advance)
      ptr_r <= ptr_r + 4'h1;
  end

  // String bytes; software may write in either mode, only the
  // advance depends on the access bit
  genvar gi;
  generate
    for (gi = 0; gi < rstc_pkg::STR_DEPTH; gi++)
    begin : g_str
      always_ff @(posedge CLK or posedge RESET)
      begin
        if (RESET)
          mem_r[gi] <= 8'h00;
        else if (wr_en && (idx == rstc_pkg::IDX_TRACE_DATA) &&
          (ptr_r == 4'(gi)))
          mem_r[gi] <= PWDATA[7:0];
      end
    end
  endgenerate

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      exp_byte_r <= 8'h00;
    else
      exp_byte_r <= mem_r[ptr_r];
  end

  ////////////////////////////////////////////////////////////////////////
  // Set and clear windows
  rstc_window #(.MODE(rstc_pkg::RSTC_SET_MODE)) u_set_win (
    .clk(CLK),
    .reset(RESET),
    .frame_tick(FRAME_TICK),
    .err_pulse(B2_ERROR),
    .win_size(set_window_size_field_r),
    .threshold(excessive_error_threshold_r),
    .done_r(set_done),
    .qual_r(set_qual),
    .run_r(set_run)
  );

  rstc_window #(.MODE(rstc_pkg::RSTC_CLR_MODE)) u_clr_win (
    .clk(CLK),
    .reset(RESET),
    .frame_tick(FRAME_TICK),
    .err_pulse(B2_ERROR),
    .win_size(clear_window_size_field_r),
    .threshold(nonexcessive_error_ceiling_r),
    .done_r(clr_done),
    .qual_r(clr_qual),
    .run_r(clr_run)
  );

  // A zero count never matches, which keeps the flag where it is
  assign flag_set = !flag_r && set_done && set_qual &&
    (set_window_count_field_r != 7'h00) &&
    (set_run >= set_window_count_field_r);
  assign flag_clr = flag_r && clr_done && clr_qual &&
    (clear_window_count_field_r != 7'h00) &&
    (clr_run >= clear_window_count_field_r);

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      flag_r <= 1'b0;
    else if (flag_set)
      flag_r <= 1'b1;
    else if (flag_clr)
      flag_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky events, write one to clear; a new event wins over the clear
  always_comb
  begin
    int_status_nxt = int_status_r;
    if (wr_en && (idx == rstc_pkg::IDX_INT_STATUS))
      int_status_nxt = int_status_r & ~PWDATA[1:0];
    if (flag_set)
      int_status_nxt[rstc_pkg::INT_SET_BIT] = 1'b1;
    if (flag_clr)
      int_status_nxt[rstc_pkg::INT_CLR_BIT] = 1'b1;
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      int_status_r <= 2'h0;
      irq_r <= 1'b0;
    end
    else
    begin
      int_status_r <= int_status_nxt;
      irq_r <= |(int_status_r & int_mask_r);
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign EXPECTED_BYTE = exp_byte_r;
  assign EXPECTED_POINTER = ptr_r;
  assign EXCESSIVE_PARITY_ERROR_FLAG = flag_r;
  assign IRQ = irq_r;

  ////////////////////////////////////////////////////////////////////////
  a_sw_ptr_step: assert property (@(posedge CLK) disable iff (RESET)
    (sw_advance && !ptr_reset_edge) |=> (ptr_r == $past(ptr_r) + 4'h1))
    else $error("software access did not advance pointer");

  a_hw_ptr_step: assert property (@(posedge CLK) disable iff (RESET)
    (!software_string_access_r && HW_PTR_ADVANCE && !ptr_reset_edge)
    |=> (ptr_r == $past(ptr_r) + 4'h1))
    else $error("hardware advance ignored");

  a_sw_mode_hold: assert property (@(posedge CLK) disable iff (RESET)
    (software_string_access_r && !data_access && !ptr_reset_edge)
    |=> $stable(ptr_r))
    else $error("pointer moved without software access");

  a_ptr_reset_edge: assert property (@(posedge CLK) disable iff (RESET)
    (wr_en && idx == rstc_pkg::IDX_TRACE_CTRL && PWDATA[0] &&
    !expected_string_pointer_reset_r) |=> (ptr_r == 4'h0))
    else $error("pointer not reset on rising edge");

  a_flag_set_run: assert property (@(posedge CLK) disable iff (RESET)
    (!flag_r && set_done && set_qual && set_window_count_field_r != 7'h00 &&
    set_run >= set_window_count_field_r) |=> flag_r ##1 flag_r)
    else $error("flag not set after run of bad windows");

  a_never_set: assert property (@(posedge CLK) disable iff (RESET)
    (!flag_r && set_window_count_field_r == 7'h00) |=> !flag_r)
    else $error("flag set with zero set count");

  a_flag_clear_run: assert property (@(posedge CLK) disable iff (RESET)
    (flag_r && clr_done && clr_qual && clear_window_count_field_r != 7'h00 &&
    clr_run >= clear_window_count_field_r) |=> !flag_r)
    else $error("flag not cleared after run of good windows");

  a_never_clear: assert property (@(posedge CLK) disable iff (RESET)
    (flag_r && clear_window_count_field_r == 7'h00) |=> flag_r)
    else $error("flag cleared with zero clear count");

  a_flag_holds: assert property (@(posedge CLK) disable iff (RESET)
    (!set_done && !clr_done) |=> $stable(flag_r))
    else $error("flag changed without window decision");

  a_irq_follows: assert property (@(posedge CLK) disable iff (RESET)
    ##1 (irq_r == |($past(int_status_r) & $past(int_mask_r))))
    else $error("interrupt output disagrees with status and mask");

  a_apb_wait: assert property (@(posedge CLK) disable iff (RESET)
    (start && PSEL && PENABLE) |=> pready_r ##1 !pready_r)
    else $error("ready not one cycle after access phase");

endmodule

// File: verification/rstc_top_tb.sv
// Self-checking bench for the section termination configuration block.
// Assumes the APB slave answers with one wait state and windows free-run.
`timescale 1ns/10ps
module rstc_top_tb;
  logic CLK, RESET, PSEL, PENABLE, PWRITE;
  logic [9:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd_data;
  logic PREADY, PSLVERR, FRAME_TICK, B2_ERROR, HW_PTR_ADVANCE, rd_err;
  logic [7:0] EXPECTED_BYTE;
  logic [rstc_pkg::PTR_W-1:0] EXPECTED_POINTER;
  logic EXCESSIVE_PARITY_ERROR_FLAG, IRQ;
  int num_errors = 0;
  int n_checks = 0;

  rstc_top dut_u (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .FRAME_TICK(FRAME_TICK),
    .B2_ERROR(B2_ERROR), .HW_PTR_ADVANCE(HW_PTR_ADVANCE),
    .EXPECTED_BYTE(EXPECTED_BYTE), .EXPECTED_POINTER(EXPECTED_POINTER),
    .EXCESSIVE_PARITY_ERROR_FLAG(EXCESSIVE_PARITY_ERROR_FLAG), .IRQ(IRQ));

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Holds the whole request until PREADY is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= {idx, 2'b00};
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1)
    begin
      num_errors++;
      $display("[FAIL] pready expected 1 seen 0");
      complete_run();
    end
    rd_data = PRDATA;
    rd_err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp,
                        input string name);
    apb(1'b0, idx, 32'h0);
    check(name, exp, rd_data);
  endtask

  task automatic ptr_chk(input logic [31:0] exp);
    @(negedge CLK);
    check("pointer", exp, EXPECTED_POINTER);
  endtask

  task automatic irq_chk(input logic [31:0] exp);
    repeat (2) @(negedge CLK);
    check("irq", exp, IRQ);
  endtask

  task automatic pulse_hw();
    @(posedge CLK);
    HW_PTR_ADVANCE <= 1'b1;
    @(posedge CLK);
    HW_PTR_ADVANCE <= 1'b0;
  endtask

  // Error pulses first, then n frame ticks; flag settles two edges later
  task automatic frames(input int n, input int errs, input logic exp);
    repeat (errs)
    begin
      @(posedge CLK);
      B2_ERROR <= 1'b1;
      @(posedge CLK);
      B2_ERROR <= 1'b0;
    end
    repeat (n)
    begin
      @(posedge CLK);
      FRAME_TICK <= 1'b1;
      @(posedge CLK);
      FRAME_TICK <= 1'b0;
    end
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    check("flag", {31'h0, exp}, EXCESSIVE_PARITY_ERROR_FLAG);
  endtask

  function automatic logic [7:0] sbyte(input int i);
    return 8'(i * 29 + 65);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    logic [7:0] idx [10] = '{rstc_pkg::IDX_CLR_SIZE_LO,
      rstc_pkg::IDX_CLR_SIZE_HI, rstc_pkg::IDX_CLR_COUNT,
      rstc_pkg::IDX_CEILING, rstc_pkg::IDX_SET_SIZE_LO,
      rstc_pkg::IDX_SET_SIZE_HI, rstc_pkg::IDX_SET_COUNT,
      rstc_pkg::IDX_THRESHOLD, rstc_pkg::IDX_TRACE_DATA,
      rstc_pkg::IDX_STATUS};
    logic [7:0] val [10] = '{8'h00, 8'h00, 8'h07, 8'h08, 8'h00, 8'h00,
      8'h03, 8'h2B, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++)
      rd_chk(idx[i], {24'h0, val[i]}, "reset value");
    rd_chk(rstc_pkg::IDX_TRACE_CTRL, 32'h0, "control reads zero");
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped error", 32'h1, {31'h0, rd_err});
    check("unmapped data", 32'h0, rd_data);
    apb(1'b1, rstc_pkg::IDX_SET_SIZE_HI, 32'h0000_00FF);
    apb(1'b1, rstc_pkg::IDX_SET_SIZE_LO, 32'h0000_00A5);
    rd_chk(rstc_pkg::IDX_SET_SIZE_HI, 32'h7, "size high");
    rd_chk(rstc_pkg::IDX_SET_SIZE_LO, 32'hA5, "size low");
    apb(1'b1, rstc_pkg::IDX_SET_SIZE_HI, 32'h0);
    apb(1'b1, rstc_pkg::IDX_SET_SIZE_LO, 32'h0);
  endtask

  task automatic test_string();
    apb(1'b1, rstc_pkg::IDX_TRACE_CTRL, 32'h2);
    apb(1'b1, rstc_pkg::IDX_TRACE_CTRL, 32'h3);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, rstc_pkg::IDX_TRACE_DATA, {24'h0, sbyte(i)});
      ptr_chk((i + 1) % 16);
    end
    apb(1'b1, rstc_pkg::IDX_TRACE_CTRL, 32'h2);
    rd_chk(rstc_pkg::IDX_TRACE_DATA, {24'h0, sbyte(0)}, "data");
    ptr_chk(1);
    apb(1'b1, rstc_pkg::IDX_TRACE_CTRL, 32'h3);
    ptr_chk(0);
    apb(1'b0, rstc_pkg::IDX_TRACE_DATA, 32'h0);
    apb(1'b1, rstc_pkg::IDX_TRACE_CTRL, 32'h3);
    ptr_chk(1);
    pulse_hw();
    ptr_chk(1);
    apb(1'b1, rstc_pkg::IDX_TRACE_CTRL, 32'h2);
    apb(1'b1, rstc_pkg::IDX_TRACE_CTRL, 32'h3);
    for (int i = 0; i < 16; i++)
      rd_chk(rstc_pkg::IDX_TRACE_DATA, {24'h0, sbyte(i)}, "readback");
    apb(1'b1, rstc_pkg::IDX_TRACE_CTRL, 32'h2);
    apb(1'b1, rstc_pkg::IDX_TRACE_CTRL, 32'h1);
    ptr_chk(0);
    repeat (3) pulse_hw();
    ptr_chk(3);
    @(negedge CLK);
    check("expected byte", {24'h0, sbyte(3)}, EXPECTED_BYTE);
    rd_chk(rstc_pkg::IDX_TRACE_DATA, {24'h0, sbyte(3)}, "hw data");
    ptr_chk(3);
  endtask

  // Windows stay eight ticks long here, so phase is known from reset
  task automatic test_set();
    apb(1'b1, rstc_pkg::IDX_INT_MASK, 32'h3);
    apb(1'b1, rstc_pkg::IDX_CLR_COUNT, 32'h0);
    apb(1'b1, rstc_pkg::IDX_SET_COUNT, 32'h2);
    apb(1'b1, rstc_pkg::IDX_THRESHOLD, 32'h3);
    frames(8, 3, 1'b0);
    frames(8, 2, 1'b0);
    frames(8, 3, 1'b0);
    frames(8, 3, 1'b1);
    check("irq set", 32'h1, IRQ);
    rd_chk(rstc_pkg::IDX_STATUS, 32'h1, "status");
    rd_chk(rstc_pkg::IDX_INT_STATUS, 32'h1, "int status");
    apb(1'b1, rstc_pkg::IDX_INT_STATUS, 32'h1);
    irq_chk(0);
    rd_chk(rstc_pkg::IDX_INT_STATUS, 32'h0, "int cleared");
    frames(16, 0, 1'b1);
  endtask

  task automatic test_clear();
    apb(1'b1, rstc_pkg::IDX_THRESHOLD, 32'hFF);
    apb(1'b1, rstc_pkg::IDX_INT_MASK, 32'h1);
    apb(1'b1, rstc_pkg::IDX_CLR_COUNT, 32'h2);
    frames(8, 9, 1'b1);
    frames(8, 8, 1'b1);
    frames(8, 0, 1'b0);
    irq_chk(0);
    rd_chk(rstc_pkg::IDX_INT_STATUS, 32'h2, "int clear event");
    apb(1'b1, rstc_pkg::IDX_INT_MASK, 32'h3);
    irq_chk(1);
    apb(1'b1, rstc_pkg::IDX_INT_STATUS, 32'h2);
    irq_chk(0);
  endtask

  task automatic test_zero_and_size();
    apb(1'b1, rstc_pkg::IDX_THRESHOLD, 32'h0);
    apb(1'b1, rstc_pkg::IDX_SET_COUNT, 32'h0);
    frames(16, 0, 1'b0);
    apb(1'b1, rstc_pkg::IDX_CLR_COUNT, 32'h0);
    apb(1'b1, rstc_pkg::IDX_SET_COUNT, 32'h1);
    frames(8, 0, 1'b1);
    apb(1'b1, rstc_pkg::IDX_THRESHOLD, 32'hFF);
    apb(1'b1, rstc_pkg::IDX_SET_SIZE_LO, 32'h1);
    apb(1'b1, rstc_pkg::IDX_CLR_SIZE_LO, 32'h1);
    apb(1'b1, rstc_pkg::IDX_CLR_COUNT, 32'h1);
    frames(8, 0, 1'b1);
    frames(8, 0, 1'b0);
    apb(1'b1, rstc_pkg::IDX_THRESHOLD, 32'h0);
    frames(16, 0, 1'b1);
    apb(1'b1, rstc_pkg::IDX_CEILING, 32'h0);
    frames(16, 9, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  initial
  begin
    RESET = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 10'h000;
    PWDATA = 32'h0;
    FRAME_TICK = 1'b0;
    B2_ERROR = 1'b0;
    HW_PTR_ADVANCE = 1'b0;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    test_regs();
    test_string();
    test_set();
    test_clear();
    test_zero_and_size();
    complete_run();
  end
endmodule
